/* common/eq_coef_regs.vh */
`ifndef EQ_COEF_REGS_VH
`define EQ_COEF_REGS_VH
// ==========================================================
// Register indices (printed offsets, byte address = 4 x index)
`define REG_CHAN_A_TAP7_COEF 12'h427
`define REG_CHAN_A_TAP8_COEF 12'h429
`define REG_CHAN_B_TAP1_COEF 12'h448
`define REG_CHAN_B_TAP2_COEF 12'h44A
`define REG_CHAN_B_TAP3_COEF 12'h44C
`define REG_CHAN_B_TAP4_COEF 12'h44E
`define REG_MODE_CTRL        12'h460
// ==========================================================
// Field layout
`define COEF_MSB      11
`define COEF_W        12
`define REG_W         16
`define CENTER_W      18
`define MODE_SINGLE_BIT 0
// ==========================================================
// Reset values
`define COEF_RESET    16'h0000
`define MODE_RESET    1'h0
`define READ_UNMAPPED 32'h00000000
`endif

/* dv/coef_bank_properties.sv */
`timescale 1ns/10ps
// ======
// Bus and tap checks
module coef_bank_properties (
  // Design ports
  input logic        clk,
  input logic        reset,
  input logic [13:0] address,
  input logic        read,
  input logic        write,
  input logic [31:0] writedata,
  input logic [3:0]  byteenable,
  input logic [31:0] readdata,
  input logic        waitrequest,
  input logic        single_mode,
  input logic [11:0] chan_a_coef_seven,
  input logic [11:0] chan_a_coef_eight,
  input logic [11:0] chan_b_coef_zero,
  input logic [11:0] chan_b_coef_one,
  input logic [11:0] chan_b_coef_two,
  input logic [11:0] chan_b_coef_three
);
  wire [11:0] idx = address[13:2];
  wire        wr  = write & ~waitrequest & (byteenable[1:0] == 2'h3);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_answer; $rose(read | write) |=> !waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_pulse; !waitrequest |=> waitrequest; endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_idle; !(read | write) |=> waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer with no request");
  property p_gap; read & ~waitrequest & (idx == 12'h428) |-> !readdata;
  endproperty
  a_gap: assert property (p_gap) else $error("unmapped read not zero");
  // Tap follows two edges after the answer, the register stage and the tap
  property p_a7; wr & (idx == 12'h427) |-> ##2
    chan_a_coef_seven == $past(writedata[11:0], 2); endproperty
  a_a7: assert property (p_a7) else $error("tap eight wrong");
  property p_a8; wr & (idx == 12'h429) |-> ##2
    chan_a_coef_eight == $past(writedata[11:0], 2); endproperty
  a_a8: assert property (p_a8) else $error("tap nine wrong");
  property p_b0; wr & (idx == 12'h448) & !single_mode |-> ##2
    chan_b_coef_zero == $past(writedata[11:0], 2); endproperty
  a_b0: assert property (p_b0) else $error("b tap one wrong");
  property p_b1; wr & (idx == 12'h44A) & !single_mode |-> ##2
    chan_b_coef_one == $past(writedata[11:0], 2); endproperty
  a_b1: assert property (p_b1) else $error("b tap two wrong");
  property p_b2; wr & (idx == 12'h44C) & !single_mode |-> ##2
    chan_b_coef_two == $past(writedata[11:0], 2); endproperty
  a_b2: assert property (p_b2) else $error("b tap three wrong");
  property p_b3; wr & (idx == 12'h44E) & !single_mode |-> ##2
    chan_b_coef_three == $past(writedata[11:0], 2); endproperty
  a_b3: assert property (p_b3) else $error("b tap four wrong");
  // Own disable, so the check still runs while reset is high
  property p_reset; disable iff (1'b0) reset |=> waitrequest &&
    ~|{chan_a_coef_seven, chan_a_coef_eight, chan_b_coef_zero,
    chan_b_coef_one, chan_b_coef_two, chan_b_coef_three}; endproperty
  a_reset: assert property (p_reset) else $error("taps not cleared");
  property p_single; single_mode & $past(single_mode) |-> ~|{chan_b_coef_zero,
    chan_b_coef_one, chan_b_coef_two, chan_b_coef_three}; endproperty
  a_single: assert property (p_single) else $error("b taps live");
  c_write: cover property (wr);
  c_read: cover property (read & ~waitrequest);
  c_single: cover property (single_mode);
endmodule
bind fir_equalizer_coefficient_bank coef_bank_properties u_props (.*);

/* dv/fir_equalizer_coefficient_bank_tb_top.sv */
`timescale 1ns/10ps
module fir_equalizer_coefficient_bank_tb_top;
  // ======
  // Signals; byte address is four times the register index
  logic        clk = 0, reset = 1, read = 0, write = 0;
  logic [13:0] address = 0;
  logic [31:0] writedata = 0, rd;
  logic [3:0]  byteenable = 4'hF;
  wire  [31:0] readdata;
  wire         waitrequest, single_mode;
  wire  [11:0] chan_a_coef_seven, chan_a_coef_eight, chan_b_coef_zero;
  wire  [11:0] chan_b_coef_one, chan_b_coef_two, chan_b_coef_three;
  wire  [71:0] taps = {chan_a_coef_seven, chan_a_coef_eight,
    chan_b_coef_zero, chan_b_coef_one, chan_b_coef_two, chan_b_coef_three};
  int          fails = 0, samples_checked = 0;
  logic [13:0] map [6] = '{14'h109C, 14'h10A4, 14'h1120, 14'h1128,
    14'h1130, 14'h1138};
  fir_equalizer_coefficient_bank u_fir_equalizer_coefficient_bank (.*);
  initial forever #2.5 clk = ~clk;
  // ======
  // Sign bit and reserved bits set; first value is the most negative
  function automatic logic [15:0] pat(int i);
    return 16'hA800 + 16'h0111 * i;
  endfunction
  task automatic finish_test;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [71:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [13:0] a, logic [15:0] d);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {16'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      fails++;
      finish_test();
    end
    rd = readdata;
    read <= 0;
    write <= 0;
    @(posedge clk);
  endtask
  // ======
  // Scenarios
  task automatic t_reset;
    chk(taps, 0);
    for (int i = 0; i < 6; i++) begin
      bus(0, map[i], 0);
      chk(rd, 0);
    end
    bus(0, 14'h10A0, 0);
    chk(rd, 0);
  endtask
  task automatic t_write;
    for (int i = 0; i < 6; i++) bus(1, map[i], pat(i));
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      chk(taps[71 - 12 * i -: 12], pat(i) & 16'hFFF);
      bus(0, map[i], 0);
      chk(rd, pat(i));
    end
  endtask
  // Partial lanes and unmapped writes are refused; reset clears all
  task automatic t_refuse;
    byteenable <= 4'h1;
    bus(1, map[0], 16'h0123);
    byteenable <= 4'hF;
    bus(0, map[0], 0);
    chk(rd, pat(0));
    bus(1, 14'h10A0, 16'h0456);
    bus(0, 14'h10A0, 0);
    chk(rd, 0);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    chk(taps, 0);
    chk(single_mode, 0);
    bus(0, map[5], 0);
    chk(rd, 0);
  endtask
  task automatic t_single;
    bus(1, 14'h1180, 1);
    repeat (2) @(posedge clk);
    chk(single_mode, 1);
    chk(taps, 72'h800911_000000000000);
    bus(0, map[2], 0);
    chk(rd, pat(2));
    bus(1, 14'h1180, 0);
    repeat (2) @(posedge clk);
    chk(single_mode, 0);
    chk(taps, 72'h800911_A22B33C44D55);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_reset();
    t_write();
    t_single();
    t_refuse();
    finish_test();
  end
endmodule

/* verilog/coef_reg.v */
`timescale 1ns/10ps
`include "eq_coef_regs.vh"
// ==========================================================
// One coefficient register; reserved bits are stored and read back
module coef_reg #(
  parameter [11:0] INDEX = 12'h000
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Write port
  input  wire        wr_en,
  input  wire [11:0] index,
  input  wire [15:0] wr_data,
  // Stored value
  output reg  [15:0] value
);
  always @(posedge clk) begin
    if (reset) begin
      value <= `COEF_RESET;
    end else if (wr_en && index == INDEX) begin
      value <= wr_data;
    end
  end
endmodule

/* verilog/fir_equalizer_coefficient_bank.v */
// Functional notes
// - Each coefficient is signed two's complement in bits 11:0.
// - Channel-A seventh register feeds the eighth tap, both modes.
// - Channel-A eighth register feeds the ninth tap, both modes.
// - Channel-B zeroth register feeds B filter first tap, dual mode.
// - Channel-B first register feeds B filter second tap, dual mode.
// - Channel-B second register feeds B filter third tap, dual mode.
// - All coefficient registers reset to zero, reserved bits included.
// - Channel-B third register feeds B filter fourth tap, dual mode.
// - Nine taps; centre tap 18-bit signed, others 12-bit.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
`include "eq_coef_regs.vh"
module fir_equalizer_coefficient_bank #(
  parameter NUM_REGS = 6
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Avalon-MM slave
  input  wire [13:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Converter mode, as seen by the filters
  output reg         single_mode,
  // Channel-A filter (or single filter) taps 8 and 9
  output reg  [11:0] chan_a_coef_seven,
  output reg  [11:0] chan_a_coef_eight,
  // Channel-B filter taps 1 to 4
  output reg  [11:0] chan_b_coef_zero,
  output reg  [11:0] chan_b_coef_one,
  output reg  [11:0] chan_b_coef_two,
  output reg  [11:0] chan_b_coef_three
);
  // ========================================================
  // Register map
  localparam [12*NUM_REGS-1:0] INDICES = {
    `REG_CHAN_B_TAP4_COEF, `REG_CHAN_B_TAP3_COEF,
    `REG_CHAN_B_TAP2_COEF, `REG_CHAN_B_TAP1_COEF,
    `REG_CHAN_A_TAP8_COEF, `REG_CHAN_A_TAP7_COEF};
  localparam [NUM_REGS-1:0] IS_B = 6'b111100;

  wire [11:0]            index = address[13:2];
  wire [15:0]            wr_word;
  wire                   wr_en;
  wire [16*NUM_REGS-1:0] values;
  wire [12*NUM_REGS-1:0] coefs;
  reg                    answered;

  // Byte lanes 0 and 1 carry the 16-bit register; upper lanes ignored
  assign wr_word = {byteenable[1] ? writedata[15:8] : 8'h00,
                    byteenable[0] ? writedata[7:0]  : 8'h00};
  assign wr_en   = write && !waitrequest;

  // ========================================================
  // Coefficient storage and tap selection
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : bank
      coef_reg #(
        .INDEX (INDICES[12*g +: 12])
      ) u_reg (
        .clk     (clk),
        .reset   (reset),
        .wr_en   (wr_en && byteenable[1:0] == 2'h3),
        .index   (index),
        .wr_data (wr_word),
        .value   (values[16*g +: 16])
      );
      tap_select u_sel (
        .single_mode (single_mode),
        .is_b_set    (IS_B[g]),
        .reg_value   (values[16*g +: 16]),
        .coef        (coefs[12*g +: 12])
      );
    end
  endgenerate

  // ========================================================
  // Tap outputs, registered
  always @(posedge clk) begin
    if (reset) begin
      chan_a_coef_seven <= {`COEF_W{1'b0}};
      chan_a_coef_eight <= {`COEF_W{1'b0}};
      chan_b_coef_zero  <= {`COEF_W{1'b0}};
      chan_b_coef_one   <= {`COEF_W{1'b0}};
      chan_b_coef_two   <= {`COEF_W{1'b0}};
      chan_b_coef_three <= {`COEF_W{1'b0}};
    end else begin
      chan_a_coef_seven <= coefs[11:0];
      chan_a_coef_eight <= coefs[23:12];
      chan_b_coef_zero  <= coefs[35:24];
      chan_b_coef_one   <= coefs[47:36];
      chan_b_coef_two   <= coefs[59:48];
      chan_b_coef_three <= coefs[71:60];
    end
  end

  // ========================================================
  // Mode control; the 18-bit centre tap lives elsewhere
  always @(posedge clk) begin
    if (reset) begin
      single_mode <= `MODE_RESET;
    end else if (wr_en && index == `REG_MODE_CTRL && byteenable[0]) begin
      single_mode <= writedata[`MODE_SINGLE_BIT];
    end
  end

  // ========================================================
  // Bus answer: one wait cycle per access, then data and release
  integer i;
  reg [31:0] next_readdata;
  always @* begin
    next_readdata = `READ_UNMAPPED;
    for (i = 0; i < NUM_REGS; i = i + 1) begin
      if (index == INDICES[12*i +: 12]) begin
        next_readdata = {16'h0000, values[16*i +: 16]};
      end
    end
    if (index == `REG_MODE_CTRL) begin
      next_readdata = {31'h00000000, single_mode};
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      answered    <= 1'b0;
      readdata    <= `READ_UNMAPPED;
    end else if ((read || write) && !answered) begin
      waitrequest <= 1'b0;
      answered    <= 1'b1;
      readdata    <= next_readdata;
    end else begin
      waitrequest <= 1'b1;
      answered    <= 1'b0;
    end
  end
endmodule

/* verilog/tap_select.v */
`timescale 1ns/10ps
`include "eq_coef_regs.vh"
// ==========================================================
// Chooses the coefficient seen by one filter tap
module tap_select (
  // Mode
  input  wire        single_mode,
  input  wire        is_b_set,
  // Register contents
  input  wire [15:0] reg_value,
  // Signed tap coefficient
  output wire [11:0] coef
);
  // B set is held at zero in single mode so it cannot disturb the filter
  assign coef = (is_b_set && single_mode) ? {`COEF_W{1'b0}}
              : reg_value[`COEF_MSB:0];
endmodule
